//--- common/sfpt_pkg.sv
// constants for the serial flash parameter table rom
// ----------------------------------------------------------------------------
// Summary of operation
// - CFI view: all tables one contiguous parameter
// - sector map section follows directly after section 1
// - CFI base 108Eh, SFDP base 1090h, offset two
// - CFI relative byte 00h reads A5h
// - CFI relative byte 01h reads length B0h
// - first basic parameter byte reads E7h
// - 4KB erase opcode reads FFh, unsupported
// - third basic byte reads FBh, read modes
// - fourth byte of first word reads FFh
// - density word reads FFh FFh FFh 03h
// - quad I/O read: 48h then opcode EBh
// - quad output read: 08h then opcode 6Bh
// - header points to 1090h, 16 double words
// ----------------------------------------------------------------------------
package sfpt_pkg;
  // address map
  localparam logic [23:0] SFPT_CFI_BASE = 24'h00108E;
  localparam logic [23:0] SFPT_SFDP_BASE = 24'h001090;
  localparam logic [23:0] SFPT_MAP_BASE = 24'h0010D8;
  localparam logic [7:0] SFPT_BFPT_LEN_DW = 8'h10;
  // cfi parameter framing
  localparam logic [7:0] SFPT_CFI_ID = 8'hA5;
  localparam logic [7:0] SFPT_CFI_LEN = 8'hB0;
  localparam int SFPT_SEC1_BYTES = 74;
  localparam int SFPT_TOTAL_BYTES = 178;
  // basic parameter words
  localparam logic [7:0] SFPT_DW1_B0 = 8'hE7;
  localparam logic [7:0] SFPT_ERASE4K_OP = 8'hFF;
  localparam logic [7:0] SFPT_DW1_B2 = 8'hFB;
  localparam logic [7:0] SFPT_DW1_B3 = 8'hFF;
  localparam logic [31:0] SFPT_DENSITY = 32'h03FFFFFF;
  localparam logic [7:0] SFPT_QIO_MODE_DUMMY = 8'h48;
  localparam logic [7:0] SFPT_QIO_OP = 8'hEB;
  localparam logic [7:0] SFPT_QO_MODE_DUMMY = 8'h08;
  localparam logic [7:0] SFPT_QO_OP = 8'h6B;
  localparam logic [7:0] SFPT_FILL = 8'hFF;
  // values held while reset is low
  localparam logic [7:0] SFPT_DATA_RST = 8'h00;
  localparam logic [23:0] SFPT_ADDR_RST = 24'h000000;
  // read engine states
  typedef enum logic [1:0] {
    SFPT_IDLE = 2'b01,
    SFPT_READ = 2'b10
  } sfpt_state_e;
endpackage

//--- design/sfpt_rom.sv
// combinational byte table for section 1 and the appended sector map
`timescale 1ns/100ps
module sfpt_rom (
  // lookup
  input wire logic [7:0] i_idx,
  output logic [7:0] o_byte
);
  import sfpt_pkg::*;

  // index is relative to the cfi base; section 2 follows at section 1 end
  always_comb begin
    o_byte = SFPT_FILL;
    unique case (i_idx)
      8'h00: o_byte = SFPT_CFI_ID;
      8'h01: o_byte = SFPT_CFI_LEN;
      8'h02: o_byte = SFPT_DW1_B0;
      8'h03: o_byte = SFPT_ERASE4K_OP;
      8'h04: o_byte = SFPT_DW1_B2;
      8'h05: o_byte = SFPT_DW1_B3;
      8'h06: o_byte = SFPT_DENSITY[7:0];
      8'h07: o_byte = SFPT_DENSITY[15:8];
      8'h08: o_byte = SFPT_DENSITY[23:16];
      8'h09: o_byte = SFPT_DENSITY[31:24];
      8'h0A: o_byte = SFPT_QIO_MODE_DUMMY;
      8'h0B: o_byte = SFPT_QIO_OP;
      8'h0C: o_byte = SFPT_QO_MODE_DUMMY;
      8'h0D: o_byte = SFPT_QO_OP;
      // remaining entries, sector map included, read as fill
      default: o_byte = SFPT_FILL;
    endcase
  end
endmodule

//--- design/sfpt_table.sv
// read engine for the discovery parameter table, one byte per strobe
`timescale 1ns/100ps
module sfpt_table (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // read command from the serial front end
  input wire logic i_start,
  input wire logic [23:0] i_addr,
  input wire logic i_next,
  input wire logic i_end,
  // data towards the host
  output logic [7:0] o_data,
  output logic o_valid,
  output logic o_busy
);
  import sfpt_pkg::*;

  // ---------------------------------------------------------------------------
  // address handling
  // ---------------------------------------------------------------------------
  sfpt_state_e state_q;
  logic [23:0] addr_q;
  logic [7:0] idx;
  logic in_range;
  logic [7:0] rom_byte;
  logic [23:0] rel;

  // both views land in one contiguous byte run; sfdp 00h is cfi 02h
  // basic table of 16 double words opens at the sfdp base; header is elsewhere
  assign rel = addr_q - SFPT_CFI_BASE;
  assign in_range = (addr_q >= SFPT_CFI_BASE) &&
                    (rel < 24'(SFPT_TOTAL_BYTES));
  assign idx = rel[7:0];

  sfpt_rom i_sfpt_rom (
    .i_idx(idx),
    .o_byte(rom_byte)
  );

  // ---------------------------------------------------------------------------
  // control
  // ---------------------------------------------------------------------------
  // end wins over start so a stale command cannot keep the engine busy
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= SFPT_IDLE;
    end else begin
      unique case (state_q)
        SFPT_IDLE: if (i_start && !i_end) state_q <= SFPT_READ;
        SFPT_READ: if (i_end) state_q <= SFPT_IDLE;
      endcase
    end
  end

  // address loads on start, steps once per byte delivered
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      addr_q <= SFPT_ADDR_RST;
    end else if (i_start && state_q == SFPT_IDLE) begin
      addr_q <= i_addr;
    end else if (state_q == SFPT_READ && i_next && !i_end) begin
      addr_q <= addr_q + 24'h000001;
    end
  end

  // registered data; outside the table the bus reads as fill
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data <= SFPT_DATA_RST;
      o_valid <= 1'b0;
    end else begin
      o_valid <= (state_q == SFPT_READ) && i_next && !i_end;
      if (state_q == SFPT_READ && i_next && !i_end) begin
        o_data <= in_range ? rom_byte : SFPT_FILL;
      end
    end
  end

  assign o_busy = (state_q == SFPT_READ);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence s_read_at(logic [23:0] a);
    state_q == SFPT_READ && i_next && !i_end && addr_q == a;
  endsequence

  property p_id;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_CFI_BASE) |=> o_valid && o_data == 8'hA5;
  endproperty
  a_id: assert property (p_id) else $error("id byte wrong");

  property p_len;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_CFI_BASE + 24'h1) |=> o_data == 8'hB0;
  endproperty
  a_len: assert property (p_len) else $error("length byte wrong");

  property p_sfdp0;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_SFDP_BASE) |=> o_data == 8'hE7;
  endproperty
  a_sfdp0: assert property (p_sfdp0) else $error("sfdp byte 0 wrong");

  property p_erase;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_SFDP_BASE + 24'h1) |=> o_data == 8'hFF;
  endproperty
  a_erase: assert property (p_erase) else $error("erase opcode wrong");

  property p_modes;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_SFDP_BASE + 24'h2) |=> o_data == 8'hFB;
  endproperty
  a_modes: assert property (p_modes) else $error("read mode byte wrong");

  property p_density;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_SFDP_BASE + 24'h7) |=> o_data == 8'h03;
  endproperty
  a_density: assert property (p_density) else $error("density msb wrong");

  property p_qio;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_SFDP_BASE + 24'h9) |=> o_data == 8'hEB;
  endproperty
  a_qio: assert property (p_qio) else $error("quad io opcode wrong");

  property p_qo;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_SFDP_BASE + 24'hB) |=> o_data == 8'h6B;
  endproperty
  a_qo: assert property (p_qo) else $error("quad out opcode wrong");

  property p_incr;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_q == SFPT_READ && i_next && !i_end) |=> addr_q == $past(addr_q) + 24'h1;
  endproperty
  a_incr: assert property (p_incr) else $error("address did not step");

  // ---------------------------------------------------------------------------
  // checks on more table bytes and on the read past the table
  // ---------------------------------------------------------------------------
  // the cfi view of the first basic byte sits two above the parameter start
  property p_dw1_low;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_CFI_BASE + 24'h2) |=> o_data == 8'hE7;
  endproperty
  a_dw1_low: assert property (p_dw1_low) else $error("first basic byte wrong");

  property p_dw1_top;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_SFDP_BASE + 24'h3) |=> o_data == 8'hFF;
  endproperty
  a_dw1_top: assert property (p_dw1_top) else $error("first word top byte wrong");

  property p_den_lo;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_SFDP_BASE + 24'h4) |=> o_data == 8'hFF;
  endproperty
  a_den_lo: assert property (p_den_lo) else $error("density lsb wrong");

  property p_qio_mode;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_SFDP_BASE + 24'h8) |=> o_data == 8'h48;
  endproperty
  a_qio_mode: assert property (p_qio_mode) else $error("quad io cycles wrong");

  property p_qo_mode;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_SFDP_BASE + 24'hA) |=> o_data == 8'h08;
  endproperty
  a_qo_mode: assert property (p_qo_mode) else $error("quad out cycles wrong");

  // one index span above the base the 8-bit index wraps; the range check must win
  property p_alias;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_read_at(SFPT_CFI_BASE + 24'h000100) |=> o_data == 8'hFF;
  endproperty
  a_alias: assert property (p_alias) else $error("read past table not fill");

  // ---------------------------------------------------------------------------
  // checks on the read protocol
  // ---------------------------------------------------------------------------
  // a byte strobe that the engine takes at this edge
  sequence s_take;
    state_q == SFPT_READ && i_next && !i_end;
  endsequence

  // command accepted from idle with the given start address
  sequence s_open(logic [23:0] a);
    state_q == SFPT_IDLE && i_start && !i_end && i_addr == a;
  endsequence

  property p_first;
    @(posedge i_clk) disable iff (!i_rst_b)
      s_open(SFPT_CFI_BASE) ##1 s_take |=> o_valid && o_data == 8'hA5;
  endproperty
  a_first: assert property (p_first) else $error("first streamed byte wrong");

  property p_load;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_q == SFPT_IDLE && i_start && !i_end) |=> o_busy && addr_q == $past(i_addr);
  endproperty
  a_load: assert property (p_load) else $error("start address not loaded");

  // a second start while busy must not move the address
  property p_refuse;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_q == SFPT_READ && i_start && !i_next && !i_end) |=> o_busy && $stable(addr_q);
  endproperty
  a_refuse: assert property (p_refuse) else $error("start taken while busy");

  property p_quiet;
    @(posedge i_clk) disable iff (!i_rst_b)
      !(state_q == SFPT_READ && i_next && !i_end) |=> !o_valid && $stable(o_data);
  endproperty
  a_quiet: assert property (p_quiet) else $error("byte without strobe");

  property p_end;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_q == SFPT_READ && i_end) |=> !o_busy && !o_valid;
  endproperty
  a_end: assert property (p_end) else $error("read not ended");

  property p_stay;
    @(posedge i_clk) disable iff (!i_rst_b)
      (state_q == SFPT_READ && !i_end) |=> o_busy;
  endproperty
  a_stay: assert property (p_stay) else $error("read dropped early");
endmodule

//--- tb/sfpt_host.sv
// host side model that streams table bytes out of the read engine
`timescale 1ns/100ps
module sfpt_host (
  // clock and returned bytes
  input wire logic i_clk,
  input wire logic [7:0] i_data,
  input wire logic i_valid,
  // read command towards the engine
  output logic o_start,
  output logic [23:0] o_addr,
  output logic o_next,
  output logic o_end
);
  logic [7:0] got [0:15];
  int cnt = 0;
  // idle request lines at time zero
  initial begin
    o_start = 1'b0;
    o_addr = 24'h000000;
    o_next = 1'b0;
    o_end = 1'b0;
  end
  // gather each valid byte in arrival order
  always @(posedge i_clk) begin
    if (i_valid) begin
      got[cnt] <= i_data;
      cnt <= cnt + 1;
    end
  end
  // start command only: raised after the first edge and taken at the second edge after the call
  task automatic open_rd(input logic [23:0] a);
    @(posedge i_clk);
    #1 cnt = 0;
    o_start = 1'b1;
    o_addr = a;
    @(posedge i_clk);
    #1 o_start = 1'b0;
    o_addr = ~a; // released: show a changed value, not the old one
  endtask
  // end of transaction; keep_next also raises a strobe that end must kill
  task automatic close_rd(input logic keep_next);
    o_end = 1'b1; // last byte is captured on this same edge
    o_next = keep_next;
    @(posedge i_clk);
    #1 o_end = 1'b0;
    o_next = 1'b0;
  endtask
  // n byte strobes with gap idle cycles between them, then end
  task automatic pull(input int n, input int gap);
    int k;
    o_next = 1'b1; // held up across back to back strobes
    for (k = 0; k < n; k++) begin
      @(posedge i_clk);
      #1;
      if (gap > 0 && k < n - 1) begin
        o_next = 1'b0;
        repeat (gap) @(posedge i_clk);
        #1 o_next = 1'b1;
      end
    end
    close_rd(1'b0);
  endtask
  // a whole read: start, strobes, end
  task automatic burst(input logic [23:0] a, input int n, input int gap);
    open_rd(a);
    pull(n, gap);
  endtask
endmodule

//--- tb/sfpt_table_tb_top.sv
// self-checking bench for the discovery parameter table read engine
`timescale 1ns/100ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module sfpt_table_tb_top;
  logic i_clk, i_rst_b, st, nx, en, vld, busy;
  logic [23:0] ad;
  logic [7:0] dat;
  int fail_count = 0;
  int checks_done = 0;
  // cfi relative bytes 00h..0Dh as the table must present them
  logic [7:0] exp_tab [0:13] = '{8'hA5, 8'hB0, 8'hE7, 8'hFF, 8'hFB, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h03, 8'h48, 8'hEB, 8'h08, 8'h6B};
  sfpt_table i_sfpt_table (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(st), .i_addr(ad),
    .i_next(nx), .i_end(en), .o_data(dat), .o_valid(vld), .o_busy(busy));
  sfpt_host i_sfpt_host (.i_clk(i_clk), .i_data(dat), .i_valid(vld), .o_start(st),
    .o_addr(ad), .o_next(nx), .o_end(en));
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // back-to-back stream over the whole cfi header and first words
  task automatic t_stream();
    int k;
    i_sfpt_host.burst(24'h00108E, 14, 0);
    `CHK("byte count", 14, i_sfpt_host.cnt)
    for (k = 0; k < 6; k++) begin
      `CHK("cfi byte", exp_tab[k], i_sfpt_host.got[k])
    end
    for (k = 6; k < 14; k++) begin
      `CHK("cfi byte", exp_tab[k], i_sfpt_host.got[k])
    end
    `CHK("busy after end", 1'b0, busy)
  endtask
  // slow read through the sfdp view: its byte 00h is cfi byte 02h
  task automatic t_sfdp();
    int k;
    i_sfpt_host.burst(24'h001090, 4, 2);
    for (k = 0; k < 4; k++) begin
      `CHK("sfdp byte", exp_tab[k + 2], i_sfpt_host.got[k])
    end
  endtask
  // start one below the table so the stream crosses into it
  task automatic t_edge();
    i_sfpt_host.burst(24'h00108D, 3, 1);
    `CHK("below table", 8'hFF, i_sfpt_host.got[0])
    `CHK("id byte", exp_tab[0], i_sfpt_host.got[1])
    `CHK("length byte", exp_tab[1], i_sfpt_host.got[2])
    i_sfpt_host.burst(24'h00118E, 1, 0);
    `CHK("past table", 8'hFF, i_sfpt_host.got[0])
  endtask
  // refused requests: start while busy, and a strobe in the cycle of end
  task automatic t_refuse();
    i_sfpt_host.open_rd(24'h00108E);
    i_sfpt_host.open_rd(24'h001090);
    i_sfpt_host.pull(1, 0);
    `CHK("start while busy", exp_tab[0], i_sfpt_host.got[0])
    i_sfpt_host.open_rd(24'h00108E);
    i_sfpt_host.close_rd(1'b1);
    @(posedge i_clk);
    #1;
    `CHK("strobe with end", 0, i_sfpt_host.cnt)
    `CHK("idle after end", 1'b0, busy)
  endtask
  // reset in mid-read, then a read straight after release
  task automatic t_reset();
    i_sfpt_host.open_rd(24'h00108E);
    `CHK("busy in read", 1'b1, busy)
    i_rst_b = 1'b0;
    #1;
    `CHK("data in reset", 8'h00, dat)
    `CHK("valid in reset", 1'b0, vld)
    `CHK("busy in reset", 1'b0, busy)
    @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    i_sfpt_host.burst(24'h00108E, 1, 0);
    `CHK("first after reset", exp_tab[0], i_sfpt_host.got[0])
  endtask
  // prints counts and verdict, then stops
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // 20 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // the run takes well under a thousand cycles
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  // reset for six cycles, then the scenarios
  initial begin
    i_rst_b = 1'b0;
    repeat (6) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    t_stream();
    t_sfdp();
    t_edge();
    t_refuse();
    t_reset();
    close_out();
  end
endmodule
